// [rtl/nfc_pkg.sv]
// Package for the flash host controller: register map, timing and carriers
package nfc_pkg;
  // Clock and timing, times in ns, counts derived by rounding up
  localparam int CLK_MHZ        = 50;
  localparam int RAND_ACC_NS    = 100;  // random_access_time, least wait
  localparam int PAGE_ACC_NS    = 25;   // page_access_time, least wait
  localparam int WE_PULSE_NS    = 50;
  localparam int WE_RECOV_NS    = 30;
  localparam int RESET_PULSE_NS = 500;  // reset_pulse_time
  localparam int RAND_CYC   = (RAND_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int PAGE_CYC   = (PAGE_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int WE_CYC     = (WE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOV_CYC  = (WE_RECOV_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_CYC  = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_CYC   = 2;  // Data pins pass two flops before capture

  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_ADDR    = 8'h04;
  localparam logic [7:0] OFF_WDATA   = 8'h08;
  localparam logic [7:0] OFF_CMD     = 8'h0C;
  localparam logic [7:0] OFF_STATUS  = 8'h10;
  localparam logic [7:0] OFF_RDATA   = 8'h14;
  localparam logic [7:0] OFF_PREFIX0 = 8'h18;

  // Control field positions and reset values
  localparam int CTRL_WORD   = 0;
  localparam int CTRL_SHORT  = 1;
  localparam int CTRL_ACCEL  = 2;
  localparam int CTRL_PROT   = 3;
  localparam int CTRL_IDMODE = 4;
  localparam logic [4:0] CTRL_RESET = 5'h01;

  // Prefix register fields: word address in [23:8], data in [7:0]
  localparam int PFX_ADDR_LSB = 8;
  localparam int PFX_COUNT    = 3;

  // Command codes written to the command register
  localparam logic [2:0] CMD_READ  = 3'h1;
  localparam logic [2:0] CMD_WRITE = 3'h2;
  localparam logic [2:0] CMD_PROG  = 3'h3;
  localparam logic [2:0] CMD_RESET = 3'h4;

  typedef enum logic [2:0] {
    NFC_IDLE  = 3'b000,
    NFC_READ  = 3'b001,
    NFC_WRITE = 3'b010,
    NFC_RECOV = 3'b011,
    NFC_RESET = 3'b100
  } nfc_state_e;

  // Software port carrier
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } nfc_req_s;

  // One bus write cycle on the flash pins
  typedef struct packed {
    logic [24:0] addr;
    logic [15:0] data;
  } nfc_cycle_s;
endpackage : nfc_pkg

// [rtl/nfc_sync.sv]
// Two-flop synchroniser for the flash data pins
`timescale 1ns/1ps
module nfc_sync #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : nfc_sync

// [rtl/nfc_host.sv]
// Host controller driving a page-mode parallel flash through its pins
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
// Notes on behaviour
// - Reads drive select and output gate low, write strobe high, address valid.
// - Command writes drive strobe and select low, output gate high.
// - In short-program mode programs use two write cycles, not four.
// - High voltage only during accelerated programming.
module nfc_host (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Software register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Flash control pins
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n,
  output logic             flash_rst_n,
  output logic             flash_word_mode,
  output logic             protect_accel_pin,
  output logic             high_program_voltage,
  // Flash address and data pins
  output logic      [24:0] flash_addr,
  input  wire logic [15:0] dq_i,
  output logic      [15:0] dq_o,
  output logic      [15:0] dq_oe,
  // Status
  output logic             busy
);
  nfc_pkg::nfc_state_e  state_r;
  nfc_pkg::nfc_req_s    req;
  nfc_pkg::nfc_cycle_s  cyc;
  logic [4:0]  ctrl_r;
  logic [25:0] addr_r;
  logic [15:0] wdata_r;
  logic [15:0] rdata_r;
  logic [23:0] prefix_r [nfc_pkg::PFX_COUNT];
  logic [2:0]  cmd_r;
  logic        cmd_go;
  logic [7:0]  cnt_r;
  logic [1:0]  step_r;
  logic [1:0]  last_step_r;
  logic        prog_r;
  logic        page_valid_r;
  logic [21:0] page_r;
  logic        page_hit;
  logic        short_eff;
  logic [15:0] dq_sync;
  logic [1:0]  pidx;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign cmd_go = req.wr && req.addr == nfc_pkg::OFF_CMD && state_r == nfc_pkg::NFC_IDLE;
  // Accelerate forces the two-cycle form
  assign short_eff = ctrl_r[nfc_pkg::CTRL_SHORT] | ctrl_r[nfc_pkg::CTRL_ACCEL];
  // Page is address bits 3 and up of the word address
  assign page_hit = page_valid_r && page_r == addr_r[25:4];
  assign pidx = short_eff ? 2'(nfc_pkg::PFX_COUNT - 1) : step_r;

  // Current write cycle: prefix cycles first, user word last
  // Prefix cycles let software build erase and buffer sequences
  always_comb begin
    cyc = '{addr: addr_r[25:1], data: wdata_r};
    if (prog_r && step_r != last_step_r) begin
      cyc.addr = {9'h000, prefix_r[pidx][23:nfc_pkg::PFX_ADDR_LSB]};
      cyc.data = {8'h00, prefix_r[pidx][7:0]};
    end
  end

  nfc_sync #(.W(16)) u_dq_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      (dq_i),
    .q      (dq_sync)
  );

  // Software-writable registers; writes ignored while busy would race the pins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r  <= nfc_pkg::CTRL_RESET;
      addr_r  <= '0;
      wdata_r <= '0;
      cmd_r   <= '0;
      for (int i = 0; i < nfc_pkg::PFX_COUNT; i++) prefix_r[i] <= '0;
    end else if (req.wr && state_r == nfc_pkg::NFC_IDLE) begin
      unique case (req.addr)
        nfc_pkg::OFF_CTRL:  ctrl_r  <= req.wdata[4:0];
        nfc_pkg::OFF_ADDR:  addr_r  <= req.wdata[25:0];
        nfc_pkg::OFF_WDATA: wdata_r <= req.wdata[15:0];
        nfc_pkg::OFF_CMD:   cmd_r   <= req.wdata[2:0];
        default: begin
          for (int i = 0; i < nfc_pkg::PFX_COUNT; i++)
            if (req.addr == nfc_pkg::OFF_PREFIX0 + 8'(4 * i)) prefix_r[i] <= req.wdata[23:0];
        end
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else if (req.rd) begin
      reg_rdata <= '0;
      unique case (req.addr)
        nfc_pkg::OFF_CTRL:   reg_rdata <= {27'h0000000, ctrl_r};
        nfc_pkg::OFF_ADDR:   reg_rdata <= {6'h00, addr_r};
        nfc_pkg::OFF_WDATA:  reg_rdata <= {16'h0000, wdata_r};
        nfc_pkg::OFF_STATUS: reg_rdata <= {27'h0000000, page_hit, state_r, busy};
        nfc_pkg::OFF_RDATA:  reg_rdata <= {16'h0000, rdata_r};
        default: begin
          for (int i = 0; i < nfc_pkg::PFX_COUNT; i++)
            if (req.addr == nfc_pkg::OFF_PREFIX0 + 8'(4 * i))
              reg_rdata <= {8'h00, prefix_r[i]};
        end
      endcase
    end
  end

  // Sequencer: one state per pin phase, counter times each phase
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r     <= nfc_pkg::NFC_IDLE;
      cnt_r       <= '0;
      step_r      <= '0;
      last_step_r <= '0;
      prog_r      <= 1'b0;
    end else begin
      unique case (state_r)
        nfc_pkg::NFC_IDLE: begin
          if (cmd_go) begin
            step_r <= '0;
            prog_r <= req.wdata[2:0] == nfc_pkg::CMD_PROG;
            last_step_r <= (req.wdata[2:0] == nfc_pkg::CMD_PROG) ?
                           (short_eff ? 2'h1 : 2'h3) : 2'h0;
            unique case (req.wdata[2:0])
              nfc_pkg::CMD_READ: begin
                state_r <= nfc_pkg::NFC_READ;
                // Same page with select still low needs only page time
                cnt_r <= 8'((page_hit ? nfc_pkg::PAGE_CYC : nfc_pkg::RAND_CYC)
                            + nfc_pkg::SYNC_CYC);
              end
              nfc_pkg::CMD_WRITE, nfc_pkg::CMD_PROG: begin
                state_r <= nfc_pkg::NFC_WRITE;
                cnt_r   <= 8'(nfc_pkg::WE_CYC - 1);
              end
              nfc_pkg::CMD_RESET: begin
                state_r <= nfc_pkg::NFC_RESET;
                cnt_r   <= 8'(nfc_pkg::RESET_CYC - 1);
              end
              default: state_r <= nfc_pkg::NFC_IDLE;
            endcase
          end
        end
        nfc_pkg::NFC_READ: begin
          if (cnt_r == 8'h00) state_r <= nfc_pkg::NFC_IDLE;
          else cnt_r <= cnt_r - 8'h01;
        end
        nfc_pkg::NFC_WRITE: begin
          if (cnt_r == 8'h00) begin
            state_r <= nfc_pkg::NFC_RECOV;
            cnt_r   <= 8'(nfc_pkg::RECOV_CYC - 1);
          end else cnt_r <= cnt_r - 8'h01;
        end
        nfc_pkg::NFC_RECOV: begin
          if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
          end else if (step_r == last_step_r) begin
            state_r <= nfc_pkg::NFC_IDLE;
            prog_r  <= 1'b0;
          end else begin
            step_r  <= step_r + 2'h1;
            state_r <= nfc_pkg::NFC_WRITE;
            cnt_r   <= 8'(nfc_pkg::WE_CYC - 1);
          end
        end
        nfc_pkg::NFC_RESET: begin
          if (cnt_r == 8'h00) state_r <= nfc_pkg::NFC_IDLE;
          else cnt_r <= cnt_r - 8'h01;
        end
        default: state_r <= nfc_pkg::NFC_IDLE;
      endcase
    end
  end

  // Control pins; select stays low after a read so page hits stay possible
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_ce_n  <= 1'b1;
      flash_oe_n  <= 1'b1;
      flash_we_n  <= 1'b1;
      flash_rst_n <= 1'b1;
    end else begin
      flash_rst_n <= !(cmd_go && req.wdata[2:0] == nfc_pkg::CMD_RESET) &&
                     !(state_r == nfc_pkg::NFC_RESET && cnt_r != 8'h00);
      if (cmd_go && req.wdata[2:0] == nfc_pkg::CMD_READ) begin
        flash_ce_n <= 1'b0;
        flash_oe_n <= 1'b0;
        flash_we_n <= 1'b1;
      end else if (cmd_go && req.wdata[2:0] != nfc_pkg::CMD_RESET && req.wdata[2:0] != 3'h0
                   && req.wdata[2:0] <= nfc_pkg::CMD_RESET) begin
        flash_ce_n <= 1'b0;
        flash_oe_n <= 1'b1;
        flash_we_n <= 1'b0;
      end else if (state_r == nfc_pkg::NFC_READ && cnt_r == 8'h00) begin
        flash_oe_n <= 1'b1;
      end else if (state_r == nfc_pkg::NFC_WRITE && cnt_r == 8'h00) begin
        // Select stays low so the strobe edge alone ends the cycle
        flash_we_n <= 1'b1;
      end else if (state_r == nfc_pkg::NFC_RECOV && cnt_r == 8'h00) begin
        flash_ce_n <= step_r == last_step_r;
        flash_we_n <= step_r == last_step_r;
      end else if (cmd_go && req.wdata[2:0] == nfc_pkg::CMD_RESET) begin
        flash_ce_n <= 1'b1;
        flash_oe_n <= 1'b1;
        flash_we_n <= 1'b1;
      end
    end
  end

  // Address and data pins; byte mode puts the byte bit on pin 15
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_addr <= '0;
      dq_o       <= '0;
      dq_oe      <= '0;
    end else begin
      flash_addr <= (state_r == nfc_pkg::NFC_IDLE) ? addr_r[25:1] : cyc.addr;
      dq_o[14:0] <= cyc.data[14:0];
      dq_o[15]   <= ctrl_r[nfc_pkg::CTRL_WORD] ? cyc.data[15] : addr_r[0];
      if (state_r == nfc_pkg::NFC_RESET || (cmd_go && req.wdata[2:0] == nfc_pkg::CMD_RESET))
        dq_oe <= '0;
      else if ((state_r == nfc_pkg::NFC_WRITE || state_r == nfc_pkg::NFC_RECOV) && !cmd_go)
        dq_oe <= ctrl_r[nfc_pkg::CTRL_WORD] ? 16'hFFFF : 16'h80FF;
      else
        // Pin 15 stays an address input in byte mode, even while reading
        dq_oe <= ctrl_r[nfc_pkg::CTRL_WORD] ? 16'h0000 : 16'h8000;
    end
  end

  // Captured read data; identify mode keeps only the low byte
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= '0;
    end else if (state_r == nfc_pkg::NFC_READ && cnt_r == 8'h00) begin
      if (ctrl_r[nfc_pkg::CTRL_IDMODE] || !ctrl_r[nfc_pkg::CTRL_WORD])
        rdata_r <= {8'h00, dq_sync[7:0]};
      else
        rdata_r <= dq_sync;
    end
  end

  // Page tracking; any deselect or reset forgets the open page
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      page_valid_r <= 1'b0;
      page_r       <= '0;
    end else if (state_r == nfc_pkg::NFC_READ && cnt_r == 8'h00) begin
      page_valid_r <= 1'b1;
      page_r       <= addr_r[25:4];
    end else if (state_r == nfc_pkg::NFC_WRITE || state_r == nfc_pkg::NFC_RESET
                 || (req.wr && req.addr == nfc_pkg::OFF_CTRL && state_r == nfc_pkg::NFC_IDLE)) begin
      page_valid_r <= 1'b0;
    end
  end

  // Mode pins; high voltage only inside a program sequence
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_word_mode      <= 1'b1;
      protect_accel_pin    <= 1'b1;
      high_program_voltage <= 1'b0;
      busy                 <= 1'b0;
    end else begin
      flash_word_mode      <= ctrl_r[nfc_pkg::CTRL_WORD];
      protect_accel_pin    <= !ctrl_r[nfc_pkg::CTRL_PROT];
      high_program_voltage <= ctrl_r[nfc_pkg::CTRL_ACCEL] && prog_r &&
                              (state_r == nfc_pkg::NFC_WRITE ||
                               (state_r == nfc_pkg::NFC_RECOV &&
                                !(cnt_r == 8'h00 && step_r == last_step_r)));
      busy <= cmd_go || (state_r != nfc_pkg::NFC_IDLE &&
              !(state_r == nfc_pkg::NFC_READ && cnt_r == 8'h00) &&
              !(state_r == nfc_pkg::NFC_RESET && cnt_r == 8'h00) &&
              !(state_r == nfc_pkg::NFC_RECOV && cnt_r == 8'h00 && step_r == last_step_r));
    end
  end

  // Helper: length of the current reset pulse
  logic [7:0] rst_low_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rst_low_r <= '0;
    else if (!flash_rst_n) rst_low_r <= rst_low_r + 8'h01;
    else rst_low_r <= '0;
  end

  read_ctl_a: assert property (@(posedge clk) disable iff (!arst_n)
    !flash_oe_n |-> !flash_ce_n && flash_we_n) else $error("read without select");
  write_ctl_a: assert property (@(posedge clk) disable iff (!arst_n)
    !flash_we_n |-> !flash_ce_n && flash_oe_n) else $error("write strobe with output gate");
  no_contend_a: assert property (@(posedge clk) disable iff (!arst_n)
    !flash_oe_n |-> dq_oe[14:0] == 15'h0000) else $error("host drives data during read");
  byte_float_a: assert property (@(posedge clk) disable iff (!arst_n)
    !flash_word_mode && flash_rst_n |-> dq_oe[14:8] == 7'h00 && dq_oe[15])
    else $error("byte mode pins");
  reset_quiet_a: assert property (@(posedge clk) disable iff (!arst_n)
    !flash_rst_n |-> flash_ce_n && flash_oe_n && flash_we_n && dq_oe == 16'h0000)
    else $error("bus active during reset");
  reset_len_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(flash_rst_n) |-> $past(rst_low_r) >= 8'(nfc_pkg::RESET_CYC - 1))
    else $error("reset pulse too short");
  hv_prog_a: assert property (@(posedge clk) disable iff (!arst_n)
    high_program_voltage |-> $past(prog_r) && busy && flash_oe_n)
    else $error("high voltage outside programming");
  short_len_a: assert property (@(posedge clk) disable iff (!arst_n)
    cmd_go && req.wdata[2:0] == nfc_pkg::CMD_PROG && short_eff |=> last_step_r == 2'h1)
    else $error("short program not two cycles");
  page_wait_a: assert property (@(posedge clk) disable iff (!arst_n)
    cmd_go && req.wdata[2:0] == nfc_pkg::CMD_READ && !page_hit
    |=> !flash_oe_n [*5] ##1 state_r == nfc_pkg::NFC_READ) else $error("random access cut short");
  rd_cov: cover property (@(posedge clk) disable iff (!arst_n)
    state_r == nfc_pkg::NFC_READ && cnt_r == 8'h00);
  hit_cov: cover property (@(posedge clk) disable iff (!arst_n)
    cmd_go && req.wdata[2:0] == nfc_pkg::CMD_READ && page_hit);
  prog_cov: cover property (@(posedge clk) disable iff (!arst_n) high_program_voltage);
  rst_cov: cover property (@(posedge clk) disable iff (!arst_n) $rose(flash_rst_n));
endmodule : nfc_host

// [bench/nfc_flash_model.sv]
// Behavioural model of the page-mode flash seen at the host's pins
`timescale 1ns/1ps
module nfc_flash_model #(
  parameter logic [7:0] ID_CODE = 8'h5D  // Arbitrary identification value
) (
  // Flash pins from the host
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        rst_n,
  input  wire logic        word_mode,
  input  wire logic        prot_pin,
  input  wire logic        hv,
  input  wire logic [24:0] addr,
  input  wire logic [15:0] dq_o,
  input  wire logic [15:0] dq_oe,
  output logic      [15:0] dq_i,
  // Observation
  output int               wr_count,
  output int               hv_wr,
  output nfc_pkg::nfc_cycle_s last_cyc,
  output int               rst_low_ns,
  output int               misuse,
  output logic             locked
);
  logic [15:0] drv;
  logic [15:0] drv_en;
  logic [15:0] word_q;
  logic        id_mode;
  realtime     t_page;
  realtime     t_addr;
  realtime     t_rst;

  initial begin
    {wr_count, hv_wr, rst_low_ns, misuse} = '0;
    id_mode = 1'b0;
    t_page  = 0.0;
    t_addr  = 0.0;
    t_rst   = 0.0;
  end

  // Floating pins show the inverse of the last device value, not a held copy
  always_comb
    for (int b = 0; b < 16; b++)
      dq_i[b] = dq_oe[b] ? dq_o[b] : (drv_en[b] ? drv[b] : ~drv[b]);

  // Access clock restarts on select or on a page change
  always @(negedge ce_n or addr[24:3]) t_page = $realtime;
  always @(addr) t_addr = $realtime;

  // Output data, re-evaluated often; stale data is shown inverted
  always begin
    #2;
    word_q = addr[15:0] ^ 16'h5A3C;
    if (id_mode)
      word_q = {8'h00, ID_CODE};
    else if (!word_mode)
      word_q = {8'h00, dq_i[15] ? word_q[15:8] : word_q[7:0]};
    drv_en = (!ce_n && !oe_n && rst_n) ? (word_mode ? 16'hFFFF : 16'h00FF) : 16'h0000;
    if ($realtime - t_page >= nfc_pkg::RAND_ACC_NS && $realtime - t_addr >= nfc_pkg::PAGE_ACC_NS)
      drv = word_q;
    else
      drv = ~word_q;
  end

  // Command latch takes address and data on the rising strobe
  always @(posedge we_n) if (!ce_n && rst_n) begin
    if (!oe_n || (!word_mode && |dq_oe[14:8]))
      misuse++;
    wr_count++;
    if (hv === 1'b1)
      hv_wr++;
    last_cyc = {addr, dq_i};
    if (dq_i[7:0] == 8'h90)
      id_mode = 1'b1;
    if (dq_i[7:0] == 8'hF0)
      id_mode = 1'b0;
  end

  // High voltage outside programming would damage the part
  always @(negedge oe_n) if (hv === 1'b1) misuse++;

  // Reset pulse aborts and returns to array read
  always @(negedge rst_n) t_rst = $realtime;
  always @(posedge rst_n) begin
    rst_low_ns = int'($realtime - t_rst);
    id_mode = 1'b0;
  end

  // Pull-up on the protect pin; high voltage lifts the boundary lock
  assign locked = (prot_pin === 1'b0) && (hv !== 1'b1);
endmodule : nfc_flash_model

// [bench/tb.sv]
// Self-checking testbench for the flash host controller
`timescale 1ns/1ps
module tb;
  localparam logic [24:0] W  = 25'h0123450;
  localparam logic [7:0]  ID = 8'h5D;  // Arbitrary identification value
  logic                clk = 1'b0;
  logic                arst_n = 1'b0;
  logic                reg_wr = 1'b0;
  logic                reg_rd = 1'b0;
  logic [7:0]          reg_addr = 8'h00;
  logic [31:0]         reg_wdata = 32'h0;
  logic [31:0]         reg_rdata;
  logic [31:0]         rd_q;
  logic [31:0]         st;
  logic                ce_n, oe_n, we_n, rst_n, word_mode, prot, hv, busy, locked;
  logic [24:0]         faddr;
  logic [15:0]         dq_i, dq_o, dq_oe;
  int                  wr_count, hv_wr, rst_low_ns, misuse, wr0;
  int                  n_mismatch = 0;
  int                  check_count = 0;
  int                  cycles = 0;
  nfc_pkg::nfc_cycle_s last_cyc;

  always #10 clk = ~clk;

  nfc_host i_nfc_host (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_ce_n(ce_n),
    .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_rst_n(rst_n), .flash_word_mode(word_mode),
    .protect_accel_pin(prot), .high_program_voltage(hv), .flash_addr(faddr), .dq_i(dq_i),
    .dq_o(dq_o), .dq_oe(dq_oe), .busy(busy));

  nfc_flash_model #(.ID_CODE(ID)) i_nfc_flash_model (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .rst_n(rst_n), .word_mode(word_mode), .prot_pin(prot), .hv(hv), .addr(faddr),
    .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .wr_count(wr_count), .hv_wr(hv_wr),
    .last_cyc(last_cyc), .rst_low_ns(rst_low_ns), .misuse(misuse), .locked(locked));

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data appear in the cycle after the strobe and hold until the next read
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask : rd

  // Issue a command and poll busy under a bound
  task automatic cmd(input logic [2:0] c);
    int n;
    n = 0;
    wr(nfc_pkg::OFF_CMD, {29'h0, c});
    do begin
      rd(nfc_pkg::OFF_STATUS);
      n++;
    end while (rd_q[0] !== 1'b0 && n < 100);
    check(rd_q[0], 1'b0);
  endtask : cmd

  task automatic rd_arr(input logic [24:0] w, input logic b);
    wr(nfc_pkg::OFF_ADDR, {6'h0, w, b});
    // Page flag before the read tells whether page time will be used
    rd(nfc_pkg::OFF_STATUS);
    st = rd_q;
    cmd(nfc_pkg::CMD_READ);
    rd(nfc_pkg::OFF_RDATA);
  endtask : rd_arr

  function automatic logic [15:0] arr(input logic [24:0] a);
    return a[15:0] ^ 16'h5A3C;
  endfunction : arr

  task automatic close_out;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  // Hang guard, well above the length of the sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    #1;
    check({ce_n, oe_n, we_n, rst_n, word_mode, prot, hv, busy}, 8'hFC);
    check(dq_oe, 16'h0);
    // Array reads, page hit and page miss
    rd_arr(W, 1'b0);
    check(rd_q, arr(W));
    rd_arr(W + 25'd3, 1'b0);
    check({st[4], rd_q}, {1'b1, 16'h0, arr(W + 25'd3)});
    rd_arr(W + 25'd8, 1'b0);
    check({st[4], rd_q}, {1'b0, 16'h0, arr(W + 25'd8)});
    // Single command write, then still array read
    wr0 = wr_count;
    wr(nfc_pkg::OFF_WDATA, 32'hBEEF);
    wr(nfc_pkg::OFF_ADDR, {6'h0, W, 1'b0});
    cmd(nfc_pkg::CMD_WRITE);
    check(wr_count - wr0, 1);
    check(last_cyc, {W, 16'hBEEF});
    rd_arr(W + 25'd1, 1'b0);
    check(rd_q, arr(W + 25'd1));
    // Long, short and accelerated programs
    for (int m = 0; m < 3; m++) begin
      wr(nfc_pkg::OFF_CTRL, m == 0 ? 32'h1 : (m == 1 ? 32'h3 : 32'h5));
      wr(nfc_pkg::OFF_PREFIX0, 32'h000555AA);
      wr(nfc_pkg::OFF_PREFIX0 + 8'h04, 32'h0002AA55);
      wr(nfc_pkg::OFF_PREFIX0 + 8'h08, 32'h000555A0);
      wr(nfc_pkg::OFF_WDATA, 32'(16'h1230 + m));
      wr(nfc_pkg::OFF_ADDR, {6'h0, 25'(W + 16 + m), 1'b0});
      wr0 = wr_count;
      cmd(nfc_pkg::CMD_PROG);
      check(wr_count - wr0, m == 0 ? 4 : 2);
      check(last_cyc, {25'(W + 16 + m), 16'(16'h1230 + m)});
    end
    // Boundary protection follows the protect level
    wr(nfc_pkg::OFF_CTRL, 32'h9);
    rd(nfc_pkg::OFF_STATUS);
    check({prot, locked, hv}, 3'b010);
    wr(nfc_pkg::OFF_CTRL, 32'h1);
    rd(nfc_pkg::OFF_STATUS);
    check({prot, locked}, 2'b10);
    // Byte configuration, both halves and one write
    wr(nfc_pkg::OFF_CTRL, 32'h0);
    rd_arr(W, 1'b1);
    check({word_mode, rd_q}, {1'b0, 16'h0, arr(W) >> 8});
    rd_arr(W, 1'b0);
    check(rd_q, {24'h0, arr(W) & 16'h00FF});
    wr(nfc_pkg::OFF_WDATA, 32'h77);
    cmd(nfc_pkg::CMD_WRITE);
    check(last_cyc.data[7:0], 8'h77);
    // Identification codes, then a reset pulse back to array read
    wr(nfc_pkg::OFF_CTRL, 32'h11);
    wr(nfc_pkg::OFF_WDATA, 32'h90);
    cmd(nfc_pkg::CMD_WRITE);
    rd_arr(W, 1'b0);
    check(rd_q, {24'h0, ID});
    cmd(nfc_pkg::CMD_RESET);
    check(rst_low_ns >= 480 && rst_low_ns <= 500, 1'b1);
    wr(nfc_pkg::OFF_CTRL, 32'h1);
    rd_arr(W, 1'b0);
    check(rd_q, arr(W));
    rd(8'hFC);
    check(rd_q, 32'h0);
    check(misuse, 0);
    check(hv_wr, 2);
    close_out();
  end
endmodule : tb
